// ==== design/sar_adc_regs.svh ====
// Register indices, field positions, reset values and timing counts of the converter control
`ifndef SAR_ADC_REGS_SVH
`define SAR_ADC_REGS_SVH

// Register indices; byte address is four times the index
`define IDX_POWER 16'hff01
`define IDX_CTRL 16'hffd0
`define IDX_PINSEL 16'hffd1
`define IDX_RESLO 16'hffd2
`define IDX_RESHI 16'hffd3
`define IDX_STATUS 16'hffd4
`define IDX_MASK 16'hffe7
`define IDX_FLAG 16'hfff7

// Control word fields
`define CTRL_CHAN_LO 0
`define CTRL_CHAN_HI 1
`define CTRL_CLKSEL 2
`define CTRL_START 3

// Power source word fields
`define PWR_DOUBLER 0
`define PWR_REG_SUPPLY 2
`define PWR_ANA_SUPPLY 3
`define PWR_WMASK 4'hd

// Reset values
`define RST_NIBBLE 4'h0
`define RST_RESULT 8'h00
`define RST_WORD 32'h0000_0000

// Interrupt vector of conversion done
`define CONV_VECTOR 16'h010e

// Conversion timing in conversion-clock cycles, and the first trial bit position
`define CONV_TOTAL_CYC 5'd21
`define SAMPLE_DELAY_CYC 5'd2
`define SAR_FIRST_CYC 5'd12
`define SAR_LAST_CYC 5'd19
`define LOAD_CYC 5'd20
`define SAR_MSB 3'd7

`endif

// ==== design/sar_adc_pkg.sv ====
// Types shared by the converter control modules
package sar_adc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } convState_t;

  typedef struct packed {
    logic half;
    logic tick;
  } selState_t;

  typedef struct packed {
    convState_t state;
    logic [1:0] chan;
    logic clkSel;
    logic [3:0] pinSel;
    logic [3:0] power;
    logic mask;
    logic flag;
    logic [7:0] result;
    logic [7:0] trial;
    logic [2:0] bitPos;
    logic [4:0] cnt;
    logic sampleHold;
    logic convRun;
    logic ack;
    logic [31:0] rdData;
    logic irq;
  } ctlState_t;

endpackage

// ==== design/conv_clock_selector.sv ====
// Conversion clock selector: low oscillator tick or high oscillator tick halved, gated by run
`timescale 1ns/10ps
`include "sar_adc_regs.svh"
module conv_clock_selector
  import sar_adc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Oscillator ticks, one mclk cycle each
  input wire logic lowOscTick,
  input wire logic highOscTick,
  // Control
  input wire logic clkSel,
  input wire logic runEn,
  // Conversion clock enable pulse
  output logic convTick
);

  selState_t s;
  selState_t next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!runEn) begin
      // Divider restarts with each conversion so the first step is a full period
      next_s.half = 1'b0;
    end else if (clkSel) begin
      if (highOscTick) begin
        next_s.half = ~s.half;
        next_s.tick = s.half; // [R3]
      end
    end else begin
      next_s.tick = lowOscTick; // [R3]
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign convTick = s.tick; // [R4]

endmodule

// ==== design/sar_adc_control.sv ====
// Control logic of the 8-bit successive-approximation converter with Wishbone registers
`timescale 1ns/10ps
`include "sar_adc_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// (R1) Pin select bit makes pin analog
// (R2) Reset returns pins to port, undriven
// (R3) Clock: low oscillator, or high halved
// (R4) Conversion clock runs only after start
// (R5) Software changes clock source only idle
// (R6) No start without clock, no stopping
// (R7) Two-bit field selects one of four
// (R8) Start bit D3 launches conversion
// (R9) Delay, sample, then eight-bit approximation
// (R10) Load result, bit 0 least significant
// (R11) Selected channel must be analog enabled
// (R12) Done flag set right after load
// (R13) Mask gates interrupt, flag always sets
// (R14) Writing one clears flag, zero keeps
// (R15) Interrupt vector is 010E
// (R16) Conversion lasts 10.5 us at 2 MHz
// (R17) Twenty-one conversion clocks per conversion
module sar_adc_control
  import sar_adc_pkg::*;
#(
  parameter int ADR_W = 18
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Oscillator ticks
  input wire logic lowOscTick,
  input wire logic highOscTick,
  // Analog core
  input wire logic compHigh,
  output logic [7:0] dacCode,
  output logic sampleHold,
  output logic [1:0] muxSel,
  output logic convClkEn,
  // Shared port pins
  output logic [3:0] analogPinSel,
  // Supply selection
  output logic analogSupplySelect,
  output logic regulatorSupplySelect,
  output logic voltageDoublerOn,
  // Interrupt
  output logic irq,
  output logic [15:0] irqVector
);

  ctlState_t s;
  ctlState_t next_s;
  logic convTick;

  function automatic logic hitIdx(input logic [ADR_W-1:0] adr, input logic [15:0] idx);
    hitIdx = (adr[ADR_W-1:2] == idx);
  endfunction

  function automatic logic [31:0] nib(input logic [3:0] v);
    nib = {28'h0000000, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Conversion clock

  conv_clock_selector u_sel (
    .mclk(mclk),
    .rstn(rstn),
    .lowOscTick(lowOscTick),
    .highOscTick(highOscTick),
    .clkSel(s.clkSel),
    .runEn(s.convRun),
    .convTick(convTick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  logic req;
  logic wrLo;
  logic doneEvt;

  always_comb begin
    next_s = s;
    req = cyc_i && stb_i && !s.ack;
    wrLo = req && we_i && sel_i[0];
    doneEvt = 1'b0;
    next_s.ack = req;

    // Register writes; only byte lane 0 carries the nibble-wide registers
    if (wrLo) begin
      if (hitIdx(adr_i, `IDX_CTRL)) begin
        // Source change mid-conversion is the caller's fault, not guarded here
        next_s.chan = {dat_i[`CTRL_CHAN_HI], dat_i[`CTRL_CHAN_LO]}; // [R7] [R5]
        next_s.clkSel = dat_i[`CTRL_CLKSEL]; // [R3]
      end
      if (hitIdx(adr_i, `IDX_PINSEL)) begin
        next_s.pinSel = dat_i[3:0]; // [R1]
      end
      if (hitIdx(adr_i, `IDX_POWER)) begin
        next_s.power = dat_i[3:0] & `PWR_WMASK;
      end
      if (hitIdx(adr_i, `IDX_MASK)) begin
        next_s.mask = dat_i[0];
      end
      if (hitIdx(adr_i, `IDX_FLAG) && dat_i[0]) begin
        next_s.flag = 1'b0; // [R14]
      end
    end

    // Conversion sequencer
    case (s.state)
      ST_IDLE: begin
        // A start while running is ignored so a result is never cut short
        if (wrLo && hitIdx(adr_i, `IDX_CTRL) && dat_i[`CTRL_START]) begin // [R8]
          next_s.state = ST_RUN;
          next_s.convRun = 1'b1; // [R4] [R6]
          next_s.cnt = 5'd0;
          next_s.trial = `RST_RESULT;
          next_s.bitPos = `SAR_MSB;
        end
      end
      ST_RUN: begin
        if (convTick) begin
          next_s.cnt = s.cnt + 5'd1; // [R17] [R16]
          if (s.cnt == `SAMPLE_DELAY_CYC - 5'd1) begin
            next_s.sampleHold = 1'b1; // [R9]
          end
          if (s.cnt == `SAR_FIRST_CYC - 5'd1) begin
            next_s.sampleHold = 1'b0;
            next_s.trial[s.bitPos] = 1'b1; // [R9]
          end
          if (s.cnt >= `SAR_FIRST_CYC && s.cnt <= `SAR_LAST_CYC) begin
            // Keep or drop the trial bit, then try the next lower one
            next_s.trial[s.bitPos] = compHigh;
            if (s.cnt != `SAR_LAST_CYC) begin
              next_s.trial[s.bitPos - 3'd1] = 1'b1;
              next_s.bitPos = s.bitPos - 3'd1;
            end
          end
          if (s.cnt == `LOAD_CYC) begin
            next_s.result = s.trial; // [R10]
            doneEvt = 1'b1;
            next_s.state = ST_IDLE;
            next_s.convRun = 1'b0;
            next_s.cnt = 5'd0;
          end
        end
      end
      default: begin
        next_s.state = ST_IDLE;
        next_s.convRun = 1'b0;
        next_s.sampleHold = 1'b0;
      end
    endcase

    // Completion sets the flag after the clear so a coincident event is kept
    if (doneEvt) begin
      next_s.flag = 1'b1; // [R12] [R13]
    end
    next_s.irq = next_s.flag && next_s.mask; // [R13]

    // Read data; unmapped indices read as zero
    next_s.rdData = `RST_WORD;
    if (req && !we_i) begin
      if (hitIdx(adr_i, `IDX_CTRL)) begin
        next_s.rdData = nib({1'b0, s.clkSel, s.chan});
      end else if (hitIdx(adr_i, `IDX_PINSEL)) begin
        next_s.rdData = nib(s.pinSel);
      end else if (hitIdx(adr_i, `IDX_RESLO)) begin
        next_s.rdData = nib(s.result[3:0]); // [R10]
      end else if (hitIdx(adr_i, `IDX_RESHI)) begin
        next_s.rdData = nib(s.result[7:4]); // [R10]
      end else if (hitIdx(adr_i, `IDX_STATUS)) begin
        next_s.rdData = nib({3'b000, s.convRun});
      end else if (hitIdx(adr_i, `IDX_POWER)) begin
        next_s.rdData = nib(s.power);
      end else if (hitIdx(adr_i, `IDX_MASK)) begin
        next_s.rdData = nib({3'b000, s.mask});
      end else if (hitIdx(adr_i, `IDX_FLAG)) begin
        next_s.rdData = nib({3'b000, s.flag});
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s.state <= ST_IDLE;
      s.chan <= 2'h0;
      s.clkSel <= 1'b0;
      s.pinSel <= `RST_NIBBLE; // [R2]
      s.power <= `RST_NIBBLE;
      s.mask <= 1'b0;
      s.flag <= 1'b0;
      s.result <= `RST_RESULT;
      s.trial <= `RST_RESULT;
      s.bitPos <= `SAR_MSB;
      s.cnt <= 5'd0;
      s.sampleHold <= 1'b0;
      s.convRun <= 1'b0;
      s.ack <= 1'b0;
      s.rdData <= `RST_WORD;
      s.irq <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops except the constant interrupt vector

  assign dat_o = s.rdData;
  assign ack_o = s.ack;
  assign dacCode = s.trial;
  assign sampleHold = s.sampleHold;
  assign muxSel = s.chan; // [R7] [R11]
  assign convClkEn = s.convRun; // [R4]
  assign analogPinSel = s.pinSel; // [R1] [R2]
  assign analogSupplySelect = s.power[`PWR_ANA_SUPPLY];
  assign regulatorSupplySelect = s.power[`PWR_REG_SUPPLY];
  assign voltageDoublerOn = s.power[`PWR_DOUBLER];
  assign irq = s.irq; // [R13]
  assign irqVector = `CONV_VECTOR; // [R15]

endmodule

// ==== verif/sar_adc_properties.sv ====
// Port checks of the converter control
`timescale 1ns/10ps
`include "sar_adc_regs.svh"
module sar_adc_properties #(
  parameter int ADR_W = 18
) (
  // Clock, reset, bus
  input wire logic mclk,
  input wire logic rstn,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  // Converter side
  input wire logic sampleHold,
  input wire logic [1:0] muxSel,
  input wire logic convClkEn,
  input wire logic [3:0] analogPinSel,
  input wire logic irq
);
  logic wr;
  logic [ADR_W-3:0] idx;
  logic [7:0] runLen;
  assign wr = cyc_i && stb_i && we_i && sel_i[0] && !ack_o;
  assign idx = adr_i[ADR_W-1:2];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Run length in cycles; a tick comes at most once a cycle
  always_ff @(posedge mclk) begin
    if (!rstn || !convClkEn) begin
      runLen <= 8'h00;
    end else begin
      runLen <= runLen + 8'h01;
    end
  end
  AST_PIN_SEL: assert property (
    wr && idx == `IDX_PINSEL |=> analogPinSel == $past(dat_i[3:0])) else $error("pin select");
  AST_MUX_SEL: assert property (
    wr && idx == `IDX_CTRL |=> muxSel == $past(dat_i[1:0])) else $error("channel");
  AST_START: assert property (
    $rose(convClkEn) |-> $past(wr && idx == `IDX_CTRL && dat_i[3])) else $error("start");
  AST_SAMPLE_DELAY: assert property (
    $rose(convClkEn) |-> !sampleHold ##1 !sampleHold) else $error("sample delay");
  AST_SAMPLE_IN_RUN: assert property (
    sampleHold |-> convClkEn) else $error("sample idle");
  AST_RUN_LEN: assert property (
    $fell(convClkEn) |-> runLen >= 8'd21) else $error("run short");
  AST_IRQ_CAUSE: assert property (
    $rose(irq) |-> $fell(convClkEn) || $past(wr && idx == `IDX_MASK)) else $error("irq");
  AST_RESET_OUT: assert property (
    !$past(rstn) |-> analogPinSel == 4'h0 && !irq && !convClkEn) else $error("reset");
  cover property ($fell(convClkEn) && irq);
  cover property ($rose(sampleHold));
  cover property (wr && idx == `IDX_FLAG && dat_i[0]);
endmodule

// ==== verif/analog_front_model.sv ====
// Analog front end: holds the chosen input, compares it with the trial code
`timescale 1ns/10ps
module analog_front_model #(
  parameter logic [31:0] VIN = 32'h0000_0000
) (
  // Clock
  input wire logic mclk,
  // Converter side
  input wire logic [1:0] muxSel,
  input wire logic sampleHold,
  input wire logic [7:0] dacCode,
  output logic compHigh
);
  logic [7:0] held = 8'h00;
  // Follows the input only while sampling, like a hold capacitor
  always @(posedge mclk) begin
    if (sampleHold) begin
      held <= VIN[muxSel*8 +: 8];
    end
  end
  assign compHigh = (held >= dacCode);
endmodule

// ==== verif/sar_adc_control_tb.sv ====
// Bench of the converter control
`timescale 1ns/10ps
`include "sar_adc_regs.svh"
module sar_adc_control_tb;
  localparam logic [31:0] VIN = 32'h5a80_01ff;
  // Rows: result, run period, mask, clock source, channel
  localparam logic [15:0] ROWS [4] = '{16'hff4c, 16'h0151, 16'h8046, 16'h5a5b};
  logic mclk, rstn, cyc, stb, we, lowTick, highTick, sh, clkEn, ack, comp, irq;
  logic [17:0] adr;
  logic [3:0] sel, pins, r;
  logic [31:0] wdat, rd, rdat;
  logic [7:0] dac;
  logic [1:0] mux;
  logic [15:0] vec;
  logic [2:0] dv;
  int errors, compares, n, p;
  sar_adc_control DUT (
    .mclk(mclk), .rstn(rstn), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rd), .ack_o(ack), .lowOscTick(lowTick),
    .highOscTick(highTick), .compHigh(comp), .dacCode(dac), .sampleHold(sh),
    .muxSel(mux), .convClkEn(clkEn), .analogPinSel(pins), .analogSupplySelect(),
    .regulatorSupplySelect(), .voltageDoublerOn(), .irq(irq), .irqVector(vec)
  );
  analog_front_model #(.VIN(VIN)) MODEL (
    .mclk(mclk), .muxSel(mux), .sampleHold(sh), .dacCode(dac), .compHigh(comp)
  );
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Low oscillator every fifth cycle, high one every second
  always @(posedge mclk) begin
    dv <= (dv == 3'd4) ? 3'd0 : dv + 3'd1;
    lowTick <= (dv == 3'd4);
    highTick <= ~highTick;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic [15:0] a, input logic w, input logic [3:0] d);
    int k;
    k = 0;
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 2'b00, 28'h0, d};
    @(posedge mclk);
    while (ack !== 1'b1 && k < 50) begin
      @(posedge mclk);
      k++;
    end
    if (k == 50) begin
      errors++;
      $display("ERROR %0t: no bus acknowledge", $time);
    end
    rdat = rd;
    {cyc, stb, we} <= 3'b000;
    @(posedge mclk);
  endtask
  task automatic print_verdict();
    if (errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    {rstn, cyc, stb, we, lowTick, highTick, adr, wdat, dv} = '0;
    {sel, errors, compares} = {4'h1, 64'h0};
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    chk(pins, 4'h0);
    chk(vec, `CONV_VECTOR);
    wb(`IDX_PINSEL, 1'b1, 4'hf);
    chk(pins, 4'hf);
    for (int i = 0; i < 4; i++) begin
      p = ROWS[i][7:4];
      wb(`IDX_MASK, 1'b1, {3'b000, ROWS[i][3]});
      wb(`IDX_CTRL, 1'b1, {1'b1, ROWS[i][2:0]});
      n = 0;
      while (clkEn === 1'b1 && n < 200) begin
        @(posedge mclk);
        n++;
      end
      chk(n >= 21 * p - 4 && n <= 22 * p + 2, 1);
      chk(mux, ROWS[i][1:0]);
      chk(irq, ROWS[i][3]);
      wb(`IDX_RESLO, 1'b0, 4'h0);
      r = rdat[3:0];
      wb(`IDX_RESHI, 1'b0, 4'h0);
      chk({rdat[3:0], r}, ROWS[i][15:8]);
      wb(`IDX_FLAG, 1'b1, 4'h0);
      wb(`IDX_FLAG, 1'b0, 4'h0);
      chk(rdat, 1);
      wb(`IDX_FLAG, 1'b1, 4'h1);
      wb(`IDX_FLAG, 1'b0, 4'h0);
      chk({rdat, irq}, 0);
    end
    wb(16'h0123, 1'b0, 4'h0);
    chk(rdat, 0);
    wb(`IDX_CTRL, 1'b1, 4'hc);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    chk({pins, clkEn, irq}, 0);
    print_verdict();
  end
  initial begin
    repeat (4000) @(posedge mclk);
    errors++;
    $display("ERROR %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule
bind sar_adc_control sar_adc_properties #(.ADR_W(ADR_W)) CHK (
  .mclk(mclk), .rstn(rstn), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .sampleHold(sampleHold), .muxSel(muxSel),
  .convClkEn(convClkEn), .analogPinSel(analogPinSel), .irq(irq)
);
